//--- rtl/gpio_exp_pkg.sv
// constants, types and register map of the eight-line port expander
package gpio_exp_pkg;
  localparam int          LINES        = 8;
  localparam int          SYS_CLK_MHZ  = 200;
  localparam int          SPIKE_NS     = 50;
  localparam int          FILT_CYC     = (SPIKE_NS * SYS_CLK_MHZ) / 1000;
  localparam int          FILT_W       = 4;
  localparam logic [4:0]  OFF_INPUT    = 5'h00;
  localparam logic [4:0]  OFF_OUTPUT   = 5'h04;
  localparam logic [4:0]  OFF_POL      = 5'h08;
  localparam logic [4:0]  OFF_DIR      = 5'h0C;
  localparam logic [4:0]  OFF_IRQ_STAT = 5'h10;
  localparam logic [4:0]  OFF_IRQ_EN   = 5'h14;
  localparam logic [4:0]  OFF_IRQ_CLR  = 5'h18;
  localparam logic [1:0]  CMD_INPUT    = 2'h0;
  localparam logic [1:0]  CMD_OUTPUT   = 2'h1;
  localparam logic [1:0]  CMD_POL      = 2'h2;
  localparam logic [1:0]  CMD_DIR      = 2'h3;
  localparam logic [7:0]  OUT_RST      = 8'hFF;
  localparam logic [7:0]  POL_RST      = 8'h00;
  localparam logic [7:0]  DIR_RST      = 8'hFF;
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_CHG      = 0;
  localparam int          IRQ_WR       = 1;
  localparam int          IRQ_RD       = 2;
  localparam logic [2:0]  IRQ_RST      = 3'h0;
  localparam logic [3:0]  BIT_LAST     = 4'h8;

  typedef struct packed {
    logic [4:0]  adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_RECV = 5'b00010,
    I_ACK  = 5'b00100,
    I_SEND = 5'b01000,
    I_MACK = 5'b10000
  } i2c_state_t;
endpackage

//--- rtl/gpio_expander.sv
// eight-line port expander: two-wire slave, register bus, port and interrupt logic
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - Each of the 8 lines is an input or an output as its direction bit says, and is driven or released to match.
// - The sensed level of each line sits in an input register and the value to drive sits in a separate output register.
// - A polarity bit per line inverts the input value returned on reads.
// - Direction, output, polarity, interrupt status and interrupt enable registers read back their contents; the interrupt clear offset reads as zero.
// - The interrupt is asserted while any input line differs from its value held in the input register.
// - The interrupt pin is open drain and active low, pulled low when asserted and released otherwise.
// - Reset loads every register with its default and returns the bus state machine to idle.
// - After reset all 8 lines are inputs and none is driven.
// - The slave address comes from 3 four-level address pins, giving 64 addresses.
// - The serial interface works with master clocks of 100 kHz, 400 kHz and 1 MHz.
// - Serial clock and data inputs are filtered for noise before the protocol logic sees them.
// - A parameter selects which variant's address map the pins decode to.
module gpio_expander #(
  parameter logic VARIANT = 1'b0
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire gpio_exp_pkg::wb_req_t   wb_req_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         irq_o,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_n_o,
  input  wire logic [1:0]              addr_sel_0_i,
  input  wire logic [1:0]              addr_sel_1_i,
  input  wire logic [1:0]              addr_sel_2_i,
  input  wire logic [7:0]              port_line_i,
  output logic [7:0]                   port_line_o,
  output logic [7:0]                   port_line_oe_n_o,
  output logic                         int_n_o,
  output logic                         int_oe_n_o
);
  logic [7:0]                  pin_s1_r;
  logic [7:0]                  pin_s2_r;
  logic [1:0]                  scl_s_r;
  logic [1:0]                  sda_s_r;
  logic [5:0]                  asel_s1_r;
  logic [5:0]                  asel_s2_r;
  logic                        scl_f_r;
  logic                        sda_f_r;
  logic                        scl_prev_r;
  logic                        sda_prev_r;
  logic [gpio_exp_pkg::FILT_W-1:0] scl_cnt_r;
  logic [gpio_exp_pkg::FILT_W-1:0] sda_cnt_r;
  logic [7:0]                  in_r;
  logic [7:0]                  out_r;
  logic [7:0]                  pol_r;
  logic [7:0]                  dir_r;
  logic                        in_init_r;
  logic [gpio_exp_pkg::IRQ_W-1:0] stat_r;
  logic [gpio_exp_pkg::IRQ_W-1:0] en_r;
  gpio_exp_pkg::i2c_state_t    st_r;
  logic [7:0]                  sh_r;
  logic [3:0]                  bit_r;
  logic [1:0]                  byte_r;
  logic                        rw_r;
  logic [1:0]                  ptr_r;
  logic                        nack_r;
  logic                        sda_drv_r;
  logic                        i2c_wr;
  logic                        i2c_rd_in;
  logic                        wb_go;
  logic                        wb_wr;
  logic                        wb_rd;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_c;
  logic                        stop_c;
  logic [6:0]                  own_addr;
  logic                        mismatch;
  // read value of a port register as seen by either bus
  function automatic logic [7:0] port_read(input logic [1:0] idx, input logic [7:0] inv,
                                           input logic [7:0] outv, input logic [7:0] polv,
                                           input logic [7:0] dirv);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      gpio_exp_pkg::CMD_INPUT:  v = inv ^ polv;
      gpio_exp_pkg::CMD_OUTPUT: v = outv;
      gpio_exp_pkg::CMD_POL:    v = polv;
      gpio_exp_pkg::CMD_DIR:    v = dirv;
    endcase
    return v;
  endfunction
  // noise filter: level passes only after staying put for the filter time
  function automatic logic [gpio_exp_pkg::FILT_W-1:0] filt_next(input logic raw, input logic cur,
                                                                input logic [gpio_exp_pkg::FILT_W-1:0] cnt);
    logic [gpio_exp_pkg::FILT_W-1:0] n;
    n = '0;
    if (raw != cur)
      n = cnt + 1'b1;
    return n;
  endfunction
  // synchronisers for every pin
  always_ff @(posedge clk_i)
  begin
    pin_s1_r  <= port_line_i;
    pin_s2_r  <= pin_s1_r;
    scl_s_r   <= {scl_s_r[0], scl_i};
    sda_s_r   <= {sda_s_r[0], sda_i};
    asel_s1_r <= {addr_sel_2_i, addr_sel_1_i, addr_sel_0_i};
    asel_s2_r <= asel_s1_r;
  end
  // spike filter on the serial pair
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_f_r    <= 1'b1;
      sda_f_r    <= 1'b1;
      scl_cnt_r  <= '0;
      sda_cnt_r  <= '0;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_cnt_r  <= filt_next(scl_s_r[1], scl_f_r, scl_cnt_r);
      sda_cnt_r  <= filt_next(sda_s_r[1], sda_f_r, sda_cnt_r);
      if (scl_cnt_r == gpio_exp_pkg::FILT_W'(gpio_exp_pkg::FILT_CYC))
        scl_f_r <= scl_s_r[1];
      if (sda_cnt_r == gpio_exp_pkg::FILT_W'(gpio_exp_pkg::FILT_CYC))
        sda_f_r <= sda_s_r[1];
      scl_prev_r <= scl_f_r;
      sda_prev_r <= sda_f_r;
    end
  end
  // 200 MHz sampling leaves ample margin at 1 MHz
  assign scl_rise = scl_f_r & ~scl_prev_r;
  assign scl_fall = ~scl_f_r & scl_prev_r;
  assign start_c  = scl_f_r & scl_prev_r & sda_prev_r & ~sda_f_r;
  assign stop_c   = scl_f_r & scl_prev_r & ~sda_prev_r & sda_f_r;
  assign own_addr = {VARIANT, asel_s2_r};
  // two-wire slave state machine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r      <= gpio_exp_pkg::I_IDLE;
      sh_r      <= 8'h00;
      bit_r     <= 4'h0;
      byte_r    <= 2'h0;
      rw_r      <= 1'b0;
      ptr_r     <= gpio_exp_pkg::CMD_INPUT;
      nack_r    <= 1'b0;
      sda_drv_r <= 1'b0;
    end
    else if (stop_c)
    begin
      st_r      <= gpio_exp_pkg::I_IDLE;
      sda_drv_r <= 1'b0;
    end
    else if (start_c)
    begin
      st_r      <= gpio_exp_pkg::I_RECV;
      bit_r     <= 4'h0;
      byte_r    <= 2'h0;
      sda_drv_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        gpio_exp_pkg::I_IDLE:
          sda_drv_r <= 1'b0;
        gpio_exp_pkg::I_RECV:
        begin
          if (scl_rise)
          begin
            sh_r  <= {sh_r[6:0], sda_f_r};
            bit_r <= bit_r + 4'h1;
          end
          else if (scl_fall && bit_r == gpio_exp_pkg::BIT_LAST)
          begin
            if (byte_r == 2'h0 && sh_r[7:1] != own_addr)
              st_r <= gpio_exp_pkg::I_IDLE;
            else
            begin
              st_r      <= gpio_exp_pkg::I_ACK;
              sda_drv_r <= 1'b1;
              if (byte_r == 2'h0)
                rw_r <= sh_r[0];
              else if (byte_r == 2'h1)
                ptr_r <= sh_r[1:0];
            end
          end
        end
        gpio_exp_pkg::I_ACK:
        begin
          if (scl_fall)
          begin
            bit_r <= 4'h0;
            if (byte_r != 2'h2)
              byte_r <= byte_r + 2'h1;
            if (rw_r)
            begin
              st_r      <= gpio_exp_pkg::I_SEND;
              sh_r      <= port_read(ptr_r, pin_s2_r, out_r, pol_r, dir_r);
              sda_drv_r <= ~port_read(ptr_r, pin_s2_r, out_r, pol_r, dir_r) >> 7 == 8'h00 ? 1'b0 : 1'b1;
            end
            else
            begin
              st_r      <= gpio_exp_pkg::I_RECV;
              sda_drv_r <= 1'b0;
            end
          end
        end
        gpio_exp_pkg::I_SEND:
        begin
          if (scl_fall)
          begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7)
            begin
              st_r      <= gpio_exp_pkg::I_MACK;
              sda_drv_r <= 1'b0;
            end
            else
            begin
              sh_r      <= {sh_r[6:0], 1'b0};
              sda_drv_r <= ~sh_r[6];
            end
          end
        end
        gpio_exp_pkg::I_MACK:
        begin
          if (scl_rise)
            nack_r <= sda_f_r;
          else if (scl_fall)
          begin
            bit_r <= 4'h0;
            if (nack_r)
              st_r <= gpio_exp_pkg::I_IDLE;
            else
            begin
              st_r      <= gpio_exp_pkg::I_SEND;
              sh_r      <= port_read(ptr_r, pin_s2_r, out_r, pol_r, dir_r);
              sda_drv_r <= ~port_read(ptr_r, pin_s2_r, out_r, pol_r, dir_r) >> 7 == 8'h00 ? 1'b0 : 1'b1;
            end
          end
        end
        default:
          st_r <= gpio_exp_pkg::I_IDLE;
      endcase
    end
  end
  assign i2c_wr    = (st_r == gpio_exp_pkg::I_RECV) && scl_fall && bit_r == gpio_exp_pkg::BIT_LAST
                     && byte_r == 2'h2 && !stop_c && !start_c;
  assign i2c_rd_in = rw_r && scl_fall && !stop_c && !start_c && ptr_r == gpio_exp_pkg::CMD_INPUT
                     && (st_r == gpio_exp_pkg::I_ACK || (st_r == gpio_exp_pkg::I_MACK && !nack_r));
  // register bus slave
  assign wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_go & wb_req_i.we & wb_req_i.sel[0];
  assign wb_rd = wb_go & ~wb_req_i.we;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_go;
      wb_dat_o <= 32'h0000_0000;
      if (wb_rd)
      begin
        unique case (wb_req_i.adr)
          gpio_exp_pkg::OFF_INPUT:    wb_dat_o[7:0] <= pin_s2_r ^ pol_r;
          gpio_exp_pkg::OFF_OUTPUT:   wb_dat_o[7:0] <= out_r;
          gpio_exp_pkg::OFF_POL:      wb_dat_o[7:0] <= pol_r;
          gpio_exp_pkg::OFF_DIR:      wb_dat_o[7:0] <= dir_r;
          gpio_exp_pkg::OFF_IRQ_STAT: wb_dat_o[gpio_exp_pkg::IRQ_W-1:0] <= stat_r;
          gpio_exp_pkg::OFF_IRQ_EN:   wb_dat_o[gpio_exp_pkg::IRQ_W-1:0] <= en_r;
          default:                    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // port configuration registers, register bus wins a same-cycle collision
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_r <= gpio_exp_pkg::OUT_RST;
      pol_r <= gpio_exp_pkg::POL_RST;
      dir_r <= gpio_exp_pkg::DIR_RST;
    end
    else if (wb_wr)
    begin
      if (wb_req_i.adr == gpio_exp_pkg::OFF_OUTPUT)
        out_r <= wb_req_i.dat[7:0];
      if (wb_req_i.adr == gpio_exp_pkg::OFF_POL)
        pol_r <= wb_req_i.dat[7:0];
      if (wb_req_i.adr == gpio_exp_pkg::OFF_DIR)
        dir_r <= wb_req_i.dat[7:0];
    end
    else if (i2c_wr)
    begin
      if (ptr_r == gpio_exp_pkg::CMD_OUTPUT)
        out_r <= sh_r;
      if (ptr_r == gpio_exp_pkg::CMD_POL)
        pol_r <= sh_r;
      if (ptr_r == gpio_exp_pkg::CMD_DIR)
        dir_r <= sh_r;
    end
  end
  // input register: captured after reset and on each read of it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_r      <= 8'h00;
      in_init_r <= 1'b1;
    end
    else
    begin
      in_init_r <= 1'b0;
      if (in_init_r || i2c_rd_in || (wb_rd && wb_req_i.adr == gpio_exp_pkg::OFF_INPUT))
        in_r <= pin_s2_r;
    end
  end
  assign mismatch = |((pin_s2_r ^ in_r) & dir_r) & ~in_init_r;
  // port drivers and open-drain change interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_line_o      <= gpio_exp_pkg::OUT_RST;
      port_line_oe_n_o <= 8'hFF;
      int_n_o          <= 1'b0;
      int_oe_n_o       <= 1'b1;
      sda_o            <= 1'b0;
      sda_oe_n_o       <= 1'b1;
    end
    else
    begin
      port_line_o      <= out_r;
      port_line_oe_n_o <= dir_r;
      int_n_o          <= 1'b0;
      int_oe_n_o       <= ~mismatch;
      sda_o            <= 1'b0;
      sda_oe_n_o       <= ~sda_drv_r;
    end
  end
  // sticky event status, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_r <= gpio_exp_pkg::IRQ_RST;
      en_r   <= gpio_exp_pkg::IRQ_RST;
      irq_o  <= 1'b0;
    end
    else
    begin
      if (wb_wr && wb_req_i.adr == gpio_exp_pkg::OFF_IRQ_EN)
        en_r <= wb_req_i.dat[gpio_exp_pkg::IRQ_W-1:0];
      stat_r <= (stat_r & ~((wb_wr && wb_req_i.adr == gpio_exp_pkg::OFF_IRQ_CLR)
                             ? wb_req_i.dat[gpio_exp_pkg::IRQ_W-1:0] : gpio_exp_pkg::IRQ_RST))
                | {i2c_rd_in, i2c_wr, mismatch};
      irq_o  <= |(stat_r & en_r);
    end
  end
endmodule

//--- testbench/i2c_master_model.sv
// two-wire bus master model at the fast-plus rate
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF = 67
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold();
    repeat (HALF) @(posedge clk_i);
  endtask
  // one bit: data set while clock low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic s);
    sda_o <= b;
    hold();
    scl_o <= 1'b1;
    hold();
    s = sda_i;
    scl_o <= 1'b0;
    hold();
  endtask
  task automatic start();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b1;
    hold();
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // reads one byte and answers with a not-acknowledge
  task automatic rx(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
  endtask
endmodule

//--- testbench/gpio_exp_monitor.sv
// assertions on the port expander pins
`timescale 1ns/1ps
module gpio_exp_monitor (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire gpio_exp_pkg::wb_req_t wb_req_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  irq_o,
  input wire logic                  scl_i,
  input wire logic                  sda_o,
  input wire logic                  sda_oe_n_o,
  input wire logic [7:0]            port_line_i,
  input wire logic [7:0]            port_line_o,
  input wire logic [7:0]            port_line_oe_n_o,
  input wire logic                  int_n_o,
  input wire logic                  int_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ok;
  assign wr_ok = wb_ack_o && wb_req_i.we && wb_req_i.sel[0];
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  rst_dflt_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
    port_line_oe_n_o == 8'hFF && int_oe_n_o && sda_oe_n_o) else $error("pins not released in reset");
  od_pins_a: assert property (int_n_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain pin drives high");
  dir_oe_a: assert property (wr_ok && wb_req_i.adr == gpio_exp_pkg::OFF_DIR |=>
    port_line_oe_n_o == $past(wb_req_i.dat[7:0])) else $error("enables do not follow direction");
  out_val_a: assert property (wr_ok && wb_req_i.adr == gpio_exp_pkg::OFF_OUTPUT |=>
    port_line_o == $past(wb_req_i.dat[7:0])) else $error("line value not the written one");
  irq_mask_a: assert property (wr_ok && wb_req_i.adr == gpio_exp_pkg::OFF_IRQ_EN &&
    wb_req_i.dat[7:0] == 8'h00 |=> !irq_o) else $error("masked interrupt still high");
  int_rel_a: assert property (wb_ack_o && !wb_req_i.we && wb_req_i.adr == gpio_exp_pkg::OFF_INPUT &&
    port_line_i == $past(port_line_i, 4) |=> ##1 int_oe_n_o) else $error("interrupt kept after read");
  sda_move_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data line moved with clock high");
  cover property (wb_ack_o && !wb_req_i.we);
  cover property ($fell(int_oe_n_o));
  cover property ($fell(sda_oe_n_o));
endmodule
bind gpio_expander gpio_exp_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_req_i, .wb_dat_o, .wb_ack_o,
  .irq_o, .scl_i, .sda_o, .sda_oe_n_o, .port_line_i, .port_line_o, .port_line_oe_n_o, .int_n_o, .int_oe_n_o);

//--- testbench/tb.sv
// self-checking bench for the port expander
`timescale 1ns/1ps
module tb;
  logic                  clk_i;
  logic                  rst_i;
  logic                  wb_cyc_i;
  logic                  wb_stb_i;
  gpio_exp_pkg::wb_req_t wb_req_i;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic                  irq_o;
  logic                  scl_m;
  logic                  sda_m;
  logic                  sda_o;
  logic                  sda_oe_n_o;
  logic                  sda_w;
  logic [1:0]            asel [3];
  logic [7:0]            ext;
  logic [7:0]            pin_o;
  logic [7:0]            pin_oe_n;
  logic                  int_n_o;
  logic                  int_oe_n_o;
  logic [7:0]            exp_q [$];
  int                    mismatches;
  int                    cmp_count;
  int                    seed;
  logic [7:0]            v;
  logic [7:0]            d;
  logic [7:0]            pv;
  logic [6:0]            a7;
  logic                  ok;
  // pulled-up data line shared with the master model
  assign sda_w = sda_m & (sda_oe_n_o | sda_o);
  gpio_expander #(.VARIANT(1'b1)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_req_i, .wb_dat_o,
    .wb_ack_o, .irq_o, .scl_i(scl_m), .sda_i(sda_w), .sda_o, .sda_oe_n_o, .addr_sel_0_i(asel[0]),
    .addr_sel_1_i(asel[1]), .addr_sel_2_i(asel[2]), .port_line_i((pin_o & ~pin_oe_n) | (ext & pin_oe_n)),
    .port_line_o(pin_o), .port_line_oe_n_o(pin_oe_n), .int_n_o, .int_oe_n_o);
  i2c_master_model pm (.clk_i, .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    cmp_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wb(input logic [4:0] a, input logic we, input logic [7:0] dv);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_req_i <= '{a, we, 4'hF, {24'h0, dv}};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
    begin
      mismatches++;
      complete_run();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wb(a, 1'b0, 8'h00);
  endtask
  task automatic await_int(input logic lvl);
    int n;
    n = 0;
    while (int_oe_n_o !== lvl && n < 64)
    begin
      @(posedge clk_i);
      n++;
    end
    check({7'h00, int_oe_n_o}, {7'h00, lvl}, "int");
    if (int_oe_n_o !== lvl)
      complete_run();
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(pin_oe_n, 8'hFF, "oe");
    check({7'h00, int_oe_n_o}, 8'h01, "int");
    rd(gpio_exp_pkg::OFF_OUTPUT, gpio_exp_pkg::OUT_RST);
    rd(gpio_exp_pkg::OFF_POL, gpio_exp_pkg::POL_RST);
    rd(gpio_exp_pkg::OFF_DIR, gpio_exp_pkg::DIR_RST);
    rd(gpio_exp_pkg::OFF_IRQ_STAT, 8'h00);
  endtask
  // lines 4..7 driven by the expander, 0..3 by the bench
  function automatic logic [7:0] pad();
    return (v & 8'hF0) | (ext & 8'h0F);
  endfunction
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_req_i.we === 1'b0)
      check(wb_dat_o[7:0], exp_q.pop_front(), "rd");
  initial
  begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial
  begin
    seed = 69;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_req_i = '0;
    ext = 8'($random(seed));
    for (int i = 0; i < 3; i++)
      asel[i] = 2'($random(seed));
    do_reset();
    v = 8'($random(seed));
    wb(gpio_exp_pkg::OFF_OUTPUT, 1'b1, v);
    wb(gpio_exp_pkg::OFF_POL, 1'b1, ~v);
    pv = ~v;
    wb(gpio_exp_pkg::OFF_DIR, 1'b1, 8'h0F);
    rd(gpio_exp_pkg::OFF_OUTPUT, v);
    rd(gpio_exp_pkg::OFF_POL, ~v);
    rd(gpio_exp_pkg::OFF_DIR, 8'h0F);
    rd(5'h1C, 8'h00);
    check(pin_oe_n, 8'h0F, "oe");
    check(pin_o, v, "out");
    rd(gpio_exp_pkg::OFF_INPUT, pad() ^ ~v);
    wb(gpio_exp_pkg::OFF_IRQ_EN, 1'b1, 8'h00);
    ext <= ext ^ 8'h01;
    await_int(1'b0);
    rd(gpio_exp_pkg::OFF_IRQ_STAT, 8'h01);
    check({7'h00, irq_o}, 8'h00, "irq");
    wb(gpio_exp_pkg::OFF_IRQ_EN, 1'b1, 8'h01);
    check({7'h00, irq_o}, 8'h01, "irq");
    rd(gpio_exp_pkg::OFF_INPUT, pad() ^ ~v);
    await_int(1'b1);
    wb(gpio_exp_pkg::OFF_IRQ_CLR, 1'b1, 8'h01);
    @(posedge clk_i);
    check({7'h00, irq_o}, 8'h00, "irq");
    a7 = {1'b1, asel[2], asel[1], asel[0]};
    v = 8'($random(seed));
    pm.start();
    pm.tx({a7, 1'b0}, ok);
    check({7'h00, ok}, 8'h01, "adr ack");
    pm.tx({6'h00, gpio_exp_pkg::CMD_OUTPUT}, ok);
    pm.tx(v, ok);
    pm.stop();
    check({7'h00, ok}, 8'h01, "dat ack");
    rd(gpio_exp_pkg::OFF_OUTPUT, v);
    check(pin_o, v, "pin");
    pm.start();
    pm.tx({a7, 1'b1}, ok);
    pm.rx(d);
    pm.stop();
    check(d, v, "ser rd");
    pm.start();
    pm.tx({a7, 1'b0}, ok);
    pm.tx({6'h00, gpio_exp_pkg::CMD_INPUT}, ok);
    pm.stop();
    check({7'h00, ok}, 8'h01, "cmd ack");
    pm.start();
    pm.tx({a7, 1'b1}, ok);
    pm.rx(d);
    pm.stop();
    check(d, pad() ^ pv, "ser in");
    rd(gpio_exp_pkg::OFF_IRQ_STAT, 8'h06);
    pm.start();
    pm.tx({a7 ^ 7'h01, 1'b0}, ok);
    pm.stop();
    check({7'h00, ok}, 8'h00, "foreign");
    do_reset();
    complete_run();
  end
endmodule
